/* mirv_consts.svh */
`ifndef MIRV_CONSTS_SVH
`define MIRV_CONSTS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define MIRV_IDX_SP_CTL   8'h0a
`define MIRV_IDX_SP_FLG   8'h0b
`define MIRV_IDX_SP_DATA  8'h0c
`define MIRV_IDX_CD_CTL   8'h0f
`define MIRV_IDX_CD_FLG   8'h10
`define MIRV_IDX_CD_DATA  8'h11
`define MIRV_IDX_TM_CTL   8'h12
`define MIRV_IDX_TM_FLG   8'h13
`define MIRV_IDX_TM_DATA  8'h19
`define MIRV_IDX_DOG      8'h1e
// ==========================================================
// Field positions
`define MIRV_CD_TRANS_EN  0
`define MIRV_CD_SHORT_DLY 1
`define MIRV_SP_IRQ_EN    7
`define MIRV_SP_MASTER    4
`define MIRV_DOG_FLAG     0
// ==========================================================
// Flag layouts per group: codec, timer, serial port
`define MIRV_CD_FLG_MASK  8'h0f
`define MIRV_TM_FLG_MASK  8'he0
`define MIRV_SP_FLG_MASK  8'h90
`define MIRV_TM_EN_MASK   8'he0
// ==========================================================
// Reset values
`define MIRV_CTL_RST      8'h00
`define MIRV_VEC_RST      16'h1ffe
// ==========================================================
// Vectors
`define MIRV_VEC_RESET    16'h1ffe
`define MIRV_VEC_SOFT     16'h1ffc
`define MIRV_VEC_MONITOR  16'h1ffa
`define MIRV_VEC_CODEC    16'h1ff8
`define MIRV_VEC_EXT      16'h1ff6
`define MIRV_VEC_TIMER    16'h1ff4
`define MIRV_VEC_SERIAL   16'h1ff2
// ==========================================================
// Oscillator stabilisation counts, in cycles
`define MIRV_DLY_FULL     12'd4064
`define MIRV_DLY_SHORT    12'd128
`define MIRV_DLY_NONE     12'd1
`endif

/* mirv_pkg.sv */
// ==========================================================
// Types shared by the controller
package mirv_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_DELAY,
    ST_RUN,
    ST_STOP,
    ST_WAIT
  } mirv_state_type;
endpackage

/* mirv_ctrl.sv */
// Summary of operation
// - Pin reset starts at 1ffe, mask set
// - Sequence starts first edge after release
// - Short-delay bit gives 128 on reset from STOP
// - Power-on clears, watchdog sets dog flag
// - Monitor reset like pin, vector 1ffa
// - Only watchdog overflow sets dog flag
// - Soft trap ignores mask, vector 1ffc
// - Four codec flags share vector 1ff8
// - Transition flag has reset-cleared enable
// - Other codec flags gated by mask only
// - Taking interrupt pushes state, sets mask
// - Pin falling edge interrupts when unmasked, 1ff6
// - Pin latch cleared on take, one kept
// - Timer flags enabled, share vector 1ff4
// - Any reset clears timer enables
// - Serial flag with enable, vector 1ff2
// - Flags clear by status then data access
// - STOP halts oscillator, forces pins
// - WAIT stops only processor clocks
// - WAIT exits on reset or interrupts
//
// Implementation choice: the APB register port.
`include "mirv_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mirv_ctrl
  import mirv_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        pin_reset_n,
  input  wire logic        ext_irq_n,
  input  wire logic        dog_expire,
  input  wire logic        slow_clock,
  input  wire logic [3:0]  codec_evt,
  input  wire logic [2:0]  timer_evt,
  input  wire logic [1:0]  serial_evt,
  input  wire logic        codec_tx,
  input  wire logic        instr_end,
  input  wire logic        soft_trap_req,
  input  wire logic        stop_req,
  input  wire logic        wait_req,
  input  wire logic        mask_clear,
  output var  logic [15:0] vector,
  output var  logic        fetch,
  output var  logic        stack_push,
  output var  logic        cpu_mask,
  output var  logic        cpu_hold,
  output var  logic        cpu_clk_en,
  output var  logic        periph_clk_en,
  output var  logic        osc_en,
  output var  logic        bus_transmit_out,
  output var  logic        serial_master
);

  // ========================================================
  // Pin synchronisers
  logic rst_s1_q, rst_s2_q;
  logic irq_s1_q, irq_s2_q, irq_s3_q;

  // Second stage only is read; third stage gives edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rst_s1_q, rst_s2_q} <= 2'h3;
      {irq_s1_q, irq_s2_q, irq_s3_q} <= 3'h7;
    end else begin
      {rst_s1_q, rst_s2_q} <= {pin_reset_n, rst_s1_q};
      {irq_s1_q, irq_s2_q, irq_s3_q} <= {ext_irq_n, irq_s1_q, irq_s2_q};
    end
  end

  wire pin_rst   = !rst_s2_q;
  wire monitor   = dog_expire | slow_clock;
  wire sys_rst   = pin_rst | monitor;
  wire irq_fall  = irq_s3_q & !irq_s2_q;

  // ========================================================
  // State and registers
  mirv_state_type  st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0]     boot_q, boot_d, vec_d;
  logic            boot_run_q, boot_run_d;
  logic            mask_q, mask_d;
  logic            fetch_d, push_d, irq_take;
  logic            irq_latch_q, dog_flag_q;
  logic [7:0]      cd_ctl_q, tm_ctl_q, sp_ctl_q;
  logic [7:0]      flags_q [3], snap_q [3];
  logic [7:0]      evt_vec [3], grp_mask [3];
  logic            pready_q, pslverr_q;
  logic [31:0]     prdata_q;

  // ========================================================
  // APB decode
  wire       setup  = psel & !penable;
  wire       acc    = psel & penable & pready_q;
  wire       wr_acc = acc & pwrite;

  // Index match, shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
    hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) && (a[9:2] == i);
  endfunction

  wire h_sp_ctl  = hit(paddr, `MIRV_IDX_SP_CTL);
  wire h_cd_ctl  = hit(paddr, `MIRV_IDX_CD_CTL);
  wire h_tm_ctl  = hit(paddr, `MIRV_IDX_TM_CTL);
  wire h_dog     = hit(paddr, `MIRV_IDX_DOG);
  wire [2:0] h_flg  = {hit(paddr, `MIRV_IDX_SP_FLG),
                       hit(paddr, `MIRV_IDX_TM_FLG),
                       hit(paddr, `MIRV_IDX_CD_FLG)};
  wire [2:0] h_data = {hit(paddr, `MIRV_IDX_SP_DATA),
                       hit(paddr, `MIRV_IDX_TM_DATA),
                       hit(paddr, `MIRV_IDX_CD_DATA)};
  wire mapped = h_sp_ctl | h_cd_ctl | h_tm_ctl | h_dog | (|h_flg) | (|h_data);

  // Read data mux; data registers of the peripherals read as zero here
  wire [7:0] rd_byte = h_sp_ctl ? sp_ctl_q :
                       h_cd_ctl ? cd_ctl_q :
                       h_tm_ctl ? tm_ctl_q :
                       h_dog    ? {7'h00, dog_flag_q} :
                       h_flg[0] ? flags_q[0] :
                       h_flg[1] ? flags_q[1] :
                       h_flg[2] ? flags_q[2] : 8'h00;

  // Zero-wait slave: ready rises one edge after the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & !mapped;
      prdata_q  <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ========================================================
  // Peripheral flags with two-step clearing
  assign grp_mask = '{`MIRV_CD_FLG_MASK, `MIRV_TM_FLG_MASK, `MIRV_SP_FLG_MASK};
  assign evt_vec  = '{{4'h0, codec_evt}, {timer_evt, 5'h00},
                      {serial_evt[1], 2'h0, serial_evt[0], 4'h0}};

  // A new event always wins over the clearing access
  generate
    for (genvar g = 0; g < 3; g++) begin : g_flags
      wire arm = acc & h_flg[g] & (|flags_q[g]);
      wire clr = acc & h_data[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[g] <= 8'h00;
          snap_q[g]  <= 8'h00;
        end else if (sys_rst) begin
          flags_q[g] <= evt_vec[g] & grp_mask[g];
          snap_q[g]  <= 8'h00;
        end else begin
          flags_q[g] <= ((flags_q[g] & ~(clr ? snap_q[g] : 8'h00))
                        | evt_vec[g]) & grp_mask[g];
          snap_q[g]  <= arm ? flags_q[g] : (clr ? 8'h00 : snap_q[g]);
        end
      end
    end
  endgenerate

  // ========================================================
  // Request gating and vector selection
  wire cd_req = (flags_q[0][0] & cd_ctl_q[`MIRV_CD_TRANS_EN])
              | (|flags_q[0][3:1]);
  wire tm_req = |(flags_q[1] & tm_ctl_q & `MIRV_TM_EN_MASK);
  wire sp_req = (|flags_q[2]) & sp_ctl_q[`MIRV_SP_IRQ_EN];
  wire any_req = cd_req | irq_latch_q | tm_req | sp_req;

  // Fixed priority among maskable sources
  wire [15:0] sel_vec = cd_req      ? `MIRV_VEC_CODEC :
                        irq_latch_q ? `MIRV_VEC_EXT :
                        tm_req      ? `MIRV_VEC_TIMER :
                                      `MIRV_VEC_SERIAL;

  // Delay on entry to reset: full or short after STOP, else none
  wire [CNT_W-1:0] stop_dly = cd_ctl_q[`MIRV_CD_SHORT_DLY] ?
                              CNT_W'(`MIRV_DLY_SHORT) : CNT_W'(`MIRV_DLY_FULL);
  wire [CNT_W-1:0] rst_dly = (st_q == ST_STOP) ? stop_dly
                                               : CNT_W'(`MIRV_DLY_NONE);

  // ========================================================
  // Sequencer
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    boot_d     = boot_q;
    boot_run_d = boot_run_q;
    mask_d     = mask_q;
    vec_d      = vector;
    fetch_d    = 1'b0;
    push_d     = 1'b0;
    irq_take   = 1'b0;
    if (sys_rst) begin
      st_d   = ST_RESET;
      mask_d = 1'b1;
      if (st_q != ST_RESET) begin
        cnt_d = rst_dly;
      end
      if (monitor) begin
        boot_d = `MIRV_VEC_MONITOR;
      end else if (st_q != ST_RESET) begin
        boot_d = `MIRV_VEC_RESET;
      end
      boot_run_d = 1'b1;
    end else begin
      unique case (st_q)
        ST_RESET: st_d = ST_DELAY;
        ST_DELAY: begin
          if (cnt_q <= CNT_W'(1)) begin
            st_d       = ST_RUN;
            boot_run_d = 1'b0;
            if (boot_run_q) begin
              fetch_d = 1'b1;
              vec_d   = boot_q;
            end
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        ST_RUN: begin
          if (instr_end && soft_trap_req) begin
            fetch_d = 1'b1;
            push_d  = 1'b1;
            mask_d  = 1'b1;
            vec_d   = `MIRV_VEC_SOFT;
          end else if (instr_end && any_req && !mask_q) begin
            fetch_d  = 1'b1;
            push_d   = 1'b1;
            mask_d   = 1'b1;
            vec_d    = sel_vec;
            irq_take = !cd_req && irq_latch_q;
          end else if (instr_end && stop_req) begin
            st_d   = ST_STOP;
            mask_d = 1'b0;
          end else if (instr_end && wait_req) begin
            st_d   = ST_WAIT;
            mask_d = 1'b0;
          end else if (mask_clear) begin
            mask_d = 1'b0;
          end
        end
        ST_STOP: begin
          // Besides a reset, only the pin latch or a codec request restarts the oscillator
          if (irq_latch_q || cd_req) begin
            st_d  = ST_DELAY;
            cnt_d = CNT_W'(`MIRV_DLY_FULL);
          end
        end
        ST_WAIT: begin
          if (any_req) begin
            st_d = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_RESET;
      cnt_q      <= CNT_W'(`MIRV_DLY_FULL);
      boot_q     <= `MIRV_VEC_RST;
      boot_run_q <= 1'b1;
      mask_q     <= 1'b1;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      boot_q     <= boot_d;
      boot_run_q <= boot_run_d;
      mask_q     <= mask_d;
    end
  end

  // ========================================================
  // CPU-facing outputs, registered from next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector        <= `MIRV_VEC_RST;
      fetch         <= 1'b0;
      stack_push    <= 1'b0;
      cpu_hold      <= 1'b1;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_en        <= 1'b1;
      bus_transmit_out <= 1'b0;
    end else begin
      vector        <= vec_d;
      fetch         <= fetch_d;
      stack_push    <= push_d;
      cpu_hold      <= (st_d == ST_RESET) || (st_d == ST_DELAY);
      cpu_clk_en    <= (st_d == ST_RUN);
      periph_clk_en <= (st_d == ST_RUN) || (st_d == ST_WAIT);
      osc_en        <= (st_d != ST_STOP);
      bus_transmit_out <= codec_tx && (st_d == ST_RUN || st_d == ST_WAIT);
    end
  end

  assign cpu_mask      = mask_q;
  assign serial_master = sp_ctl_q[`MIRV_SP_MASTER];
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;

  // ========================================================
  // External pin latch: holds one pulse while masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_latch_q <= 1'b0;
    end else if (sys_rst) begin
      irq_latch_q <= 1'b0;
    end else begin
      irq_latch_q <= irq_fall | (irq_latch_q & !irq_take);
    end
  end

  // ========================================================
  // Dog flag: cleared only by power-on, pin reset leaves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_flag_q <= 1'b0;
    end else if (dog_expire) begin
      dog_flag_q <= 1'b1;
    end
  end

  // ========================================================
  // Control registers; every reset clears the enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cd_ctl_q <= `MIRV_CTL_RST;
      tm_ctl_q <= `MIRV_CTL_RST;
      sp_ctl_q <= `MIRV_CTL_RST;
    end else if (sys_rst) begin
      cd_ctl_q <= `MIRV_CTL_RST;
      tm_ctl_q <= `MIRV_CTL_RST;
      sp_ctl_q <= `MIRV_CTL_RST;
    end else begin
      if (wr_acc && h_cd_ctl) begin
        cd_ctl_q <= pwdata[7:0];
      end
      if (wr_acc && h_tm_ctl) begin
        tm_ctl_q <= pwdata[7:0];
      end
      if (st_d == ST_STOP) begin
        sp_ctl_q[`MIRV_SP_MASTER] <= 1'b0;
      end else if (wr_acc && h_sp_ctl) begin
        sp_ctl_q <= pwdata[7:0];
      end
    end
  end

  // ========================================================
  // Checks
  chk_soft_trap: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && instr_end && soft_trap_req && !sys_rst)
    |=> (fetch && stack_push && vector == 16'h1ffc && cpu_mask))
    else $error("soft trap not taken through its vector");
  chk_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && instr_end && !soft_trap_req && mask_q)
    |=> !stack_push)
    else $error("interrupt taken while masked");
  chk_dog_set: assert property (@(posedge pclk) disable iff (!presetn)
    dog_expire |=> (dog_flag_q && st_q == ST_RESET && boot_q == 16'h1ffa))
    else $error("watchdog restart did not set flag or vector");
  chk_pin_keeps_dog: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_rst && !dog_expire) |=> $stable(dog_flag_q))
    else $error("pin reset changed the dog flag");
  chk_short_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_STOP && sys_rst && cd_ctl_q[`MIRV_CD_SHORT_DLY])
    |=> (cnt_q == 12'd128))
    else $error("short stabilisation delay not loaded");
  chk_release_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RESET && $rose(rst_s2_q) && !monitor)
    |=> (st_q == ST_DELAY))
    else $error("reset sequence did not start after release");
  chk_stop_pins: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_STOP) |-> (!osc_en && !bus_transmit_out && !serial_master))
    else $error("stop state pins not forced");
  chk_wait_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_WAIT) |-> (!cpu_clk_en && periph_clk_en))
    else $error("wait state clocks wrong");

endmodule
`default_nettype wire

/* mirv_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// CPU core stand-in: instruction boundaries and mask release
module mirv_cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic cli_req,
  input  wire logic cpu_hold,
  input  wire logic cpu_clk_en,
  output var  logic instr_end,
  output var  logic mask_clear
);
  logic [1:0] phase_q;

  // Boundaries only while clocked; slow mode gives one in four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q    <= 2'h0;
      instr_end  <= 1'b0;
      mask_clear <= 1'b0;
    end else begin
      phase_q    <= phase_q + 2'h1;
      instr_end  <= !cpu_hold && cpu_clk_en && (!slow || phase_q == 2'h0);
      mask_clear <= cli_req; // Return only once service is over
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`include "mirv_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top import mirv_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pin_reset_n, ext_irq_n, dog_expire, slow_clock, codec_tx;
  logic [3:0]  codec_evt;
  logic [2:0]  timer_evt;
  logic [1:0]  serial_evt;
  logic        instr_end, soft_trap_req, stop_req, wait_req, mask_clear;
  logic        slow, cli_req, fetch, stack_push, cpu_mask, cpu_hold;
  logic        cpu_clk_en, periph_clk_en, osc_en, bus_transmit_out, serial_master;
  logic [15:0] vector, f_vec;
  logic        f_push;
  logic [7:0]  st_idx [4];
  logic [7:0]  dt_idx [4];
  logic [7:0]  flg [4];
  int          bad_count, total_checks, n, k, t, s, j, c;
  int          seed = 32'h0952418b;
  int          src_q[$];
  int          cause [3] = '{2, 0, 1};

  mirv_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_reset_n, .ext_irq_n, .dog_expire, .slow_clock, .codec_evt,
    .timer_evt, .serial_evt, .codec_tx, .instr_end, .soft_trap_req, .stop_req,
    .wait_req, .mask_clear, .vector, .fetch, .stack_push, .cpu_mask, .cpu_hold,
    .cpu_clk_en, .periph_clk_en, .osc_en, .bus_transmit_out, .serial_master);

  mirv_cpu_model cpu (.pclk, .presetn, .slow, .cli_req, .cpu_hold, .cpu_clk_en,
    .instr_end, .mask_clear);

  // ==========================================================
  // Clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // Comparison and closing
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic fail_out();
    bad_count++;
    $display("CHECK FAILED wait expected answer seen timeout");
    give_verdict();
  endtask

  // ==========================================================
  // Bus and CPU drivers; idle edge first so no signal is set twice
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int w;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= {2'h0, idx, 2'h0};
    pwrite  <= wr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (w = 0; w < 20; w++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w == 20) fail_out();
  endtask

  task automatic rdchk(logic [7:0] idx, logic [31:0] exp, string what);
    apb(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic wait_fetch(input int bound);
    for (n = 1; n <= bound; n++) begin
      @(posedge pclk);
      if (fetch === 1'b1) break;
    end
    f_vec  = vector;
    f_push = stack_push;
    if (n > bound) fail_out();
  endtask

  // Request held for exactly one instruction boundary
  task automatic cpu_req(input int kind);
    int w;
    @(posedge pclk);
    soft_trap_req <= (kind == 0);
    stop_req      <= (kind == 1);
    wait_req      <= (kind == 2);
    for (w = 0; w < 40; w++) begin
      @(posedge pclk);
      if (instr_end === 1'b1) break;
    end
    soft_trap_req <= 1'b0;
    stop_req      <= 1'b0;
    wait_req      <= 1'b0;
    if (w == 40) fail_out();
  endtask

  task automatic cli();
    @(posedge pclk);
    cli_req <= 1'b1;
    @(posedge pclk);
    cli_req <= 1'b0;
  endtask

  task automatic no_fetch(input int cycles);
    int h = 0;
    repeat (cycles) begin
      @(posedge pclk);
      if (fetch !== 1'b0) h++;
    end
    check("quiet", h, 0);
  endtask

  task automatic pulse_ext();
    @(posedge pclk);
    ext_irq_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_irq_n <= 1'b1;
  endtask

  task automatic power_on();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_fetch(5000);
    check("por vector", 32'(f_vec), `MIRV_VEC_RESET);
    check("por start", 32'(n >= 4064 && n <= 4070), 1);
    check("por mask", cpu_mask, 1);
    check("por hold", cpu_hold, 0);
  endtask

  function automatic logic [15:0] vec_of(int src);
    case (src)
      0: return `MIRV_VEC_CODEC;
      1: return `MIRV_VEC_EXT;
      2: return `MIRV_VEC_TIMER;
      default: return `MIRV_VEC_SERIAL;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, dog_expire, slow_clock} = '0;
    {codec_evt, timer_evt, serial_evt, codec_tx, soft_trap_req} = '0;
    {stop_req, wait_req, slow, cli_req} = '0;
    pin_reset_n = 1'b1;
    ext_irq_n   = 1'b1;
    power_on();
    rdchk(`MIRV_IDX_CD_CTL, 0, "codec enable");
    rdchk(`MIRV_IDX_TM_CTL, 0, "timer enables");
    apb(1'b1, `MIRV_IDX_TM_FLG, 32'hff);
    rdchk(`MIRV_IDX_TM_FLG, 0, "timer flags");
    apb(1'b0, 8'h05, 32'h0);
    check("unmapped err", err, 1);
    $display("test reset done");
    // Soft trap while masked, slow boundaries
    slow <= 1'b1;
    cpu_req(0);
    wait_fetch(40);
    check("trap vector", 32'(f_vec), `MIRV_VEC_SOFT);
    check("trap push", f_push, 1);
    slow <= 1'b0;
    $display("test trap done");
    // All four maskable groups at once, served by priority
    apb(1'b1, `MIRV_IDX_TM_CTL, 32'he0);
    apb(1'b1, `MIRV_IDX_SP_CTL, 32'h80);
    apb(1'b1, `MIRV_IDX_CD_CTL, 32'h01);
    rdchk(`MIRV_IDX_TM_CTL, 32'he0, "timer control");
    k = 1 + ($unsigned($random(seed)) % 3);
    t = $unsigned($random(seed)) % 3;
    s = $unsigned($random(seed)) % 2;
    st_idx = '{`MIRV_IDX_CD_FLG, 8'h00, `MIRV_IDX_TM_FLG, `MIRV_IDX_SP_FLG};
    dt_idx = '{`MIRV_IDX_CD_DATA, 8'h00, `MIRV_IDX_TM_DATA, `MIRV_IDX_SP_DATA};
    flg = '{8'(1 << k), 8'h00, 8'(32'h20 << t), (s == 1) ? 8'h80 : 8'h10};
    @(posedge pclk);
    codec_evt  <= 4'(1 << k);
    timer_evt  <= 3'(1 << t);
    serial_evt <= 2'(1 << s);
    ext_irq_n  <= 1'b0;
    @(posedge pclk);
    {codec_evt, timer_evt, serial_evt} <= '0;
    repeat (3) @(posedge pclk);
    ext_irq_n <= 1'b1;
    no_fetch(20);
    src_q = {0, 1, 2, 3};
    for (j = 0; j < src_q.size(); j++) begin
      cli();
      wait_fetch(50);
      check("vector", 32'(f_vec), 32'(vec_of(src_q[j])));
      check("push", f_push, 1);
      check("mask", cpu_mask, 1);
      if (src_q[j] == 1 && j == 1) begin
        pulse_ext(); // Sent during the service routine, held by the latch while masked
        src_q.insert(j + 1, 1);
      end else if (src_q[j] != 1) begin
        rdchk(st_idx[src_q[j]], 32'(flg[src_q[j]]), "status");
        apb(1'b0, dt_idx[src_q[j]], 32'h0);
        rdchk(st_idx[src_q[j]], 0, "flags cleared");
      end
    end
    $display("test priority done");
    // Transition flag blocked by its own enable
    apb(1'b1, `MIRV_IDX_CD_CTL, 32'h00);
    codec_evt <= 4'h1;
    @(posedge pclk);
    codec_evt <= 4'h0;
    cli();
    no_fetch(20);
    rdchk(`MIRV_IDX_CD_FLG, 1, "transition flag");
    apb(1'b0, `MIRV_IDX_CD_DATA, 32'h0);
    $display("test enable done");
    // WAIT keeps peripherals clocked, exits on timer request
    apb(1'b1, `MIRV_IDX_TM_CTL, 32'he0);
    cpu_req(2);
    repeat (3) @(posedge pclk);
    check("wait cpu clk", cpu_clk_en, 0);
    check("wait periph clk", periph_clk_en, 1);
    timer_evt <= 3'h1;
    @(posedge pclk);
    timer_evt <= 3'h0;
    wait_fetch(50);
    check("wait exit", 32'(f_vec), `MIRV_VEC_TIMER);
    rdchk(`MIRV_IDX_TM_FLG, 32'h20, "overflow flag");
    apb(1'b0, `MIRV_IDX_TM_DATA, 32'h0);
    $display("test wait done");
    // STOP, then pin reset with short delay selected
    apb(1'b1, `MIRV_IDX_CD_CTL, 32'h02);
    apb(1'b1, `MIRV_IDX_SP_CTL, 32'h10);
    codec_tx <= 1'b1;
    repeat (2) @(posedge pclk);
    check("master set", serial_master, 1);
    check("tx passes", bus_transmit_out, 1);
    cpu_req(1);
    repeat (3) @(posedge pclk);
    check("osc off", osc_en, 0);
    check("tx low", bus_transmit_out, 0);
    check("slave mode", serial_master, 0);
    pin_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_reset_n <= 1'b1;
    wait_fetch(400);
    check("stop wake vector", 32'(f_vec), `MIRV_VEC_RESET);
    check("short delay", 32'(n >= 128 && n <= 140), 1);
    // Pin interrupt restarts the oscillator after the full delay
    cpu_req(1);
    pulse_ext();
    wait_fetch(4200);
    check("stop irq wake", 32'(f_vec), `MIRV_VEC_EXT);
    check("stop irq delay", 32'(n >= 4064), 1);
    $display("test stop done");
    // Slow clock, watchdog and pin restarts in turn
    for (j = 0; j < 3; j++) begin
      c = cause[j];
      apb(1'b1, `MIRV_IDX_TM_CTL, 32'he0);
      @(posedge pclk);
      slow_clock  <= (c == 2);
      dog_expire  <= (c == 0);
      pin_reset_n <= (c != 1);
      @(posedge pclk);
      {slow_clock, dog_expire} <= 2'h0;
      if (c == 1) repeat (3) @(posedge pclk);
      pin_reset_n <= 1'b1;
      wait_fetch(200);
      check("restart vector", 32'(f_vec),
            (c == 1) ? `MIRV_VEC_RESET : `MIRV_VEC_MONITOR);
      check("restart push", f_push, 0);
      rdchk(`MIRV_IDX_DOG, 32'(j != 0), "dog flag");
      rdchk(`MIRV_IDX_TM_CTL, 0, "timer enables");
    end
    power_on();
    rdchk(`MIRV_IDX_DOG, 0, "dog flag");
    $display("test restart done");
    give_verdict();
  end
endmodule
`default_nettype wire
